/* File: codec_port_slot_enable.sv */
// codec port slot gating with axi4-lite registers and a bit clock domain
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module codec_port_slot_enable #(
  parameter int unsigned WORD_BITS = codec_slot_pkg::WORD_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n
);
  localparam int unsigned CNT_W = $clog2(WORD_BITS);
  localparam int unsigned SW = codec_slot_pkg::SLOT_IDX_BITS;
  localparam int unsigned NS = codec_slot_pkg::SLOT_COUNT;
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_BITS - 1);

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  // register side, clk domain
  logic [NS-1:0] rx_en_reg, rx_en_next;
  logic [NS-1:0] tx_en_reg, tx_en_next;
  logic [15:0] tx_data_reg, tx_data_next;
  logic mode_reg, mode_next;
  logic tx_tgl_reg, tx_tgl_next;
  logic [WORD_BITS-1:0] rx_word_q_reg, rx_word_q_next;
  logic [SW-1:0] rx_slot_q_reg, rx_slot_q_next;
  logic rx_fresh_reg, rx_fresh_next;
  logic rx_seen_reg, rx_seen_next;
  logic aw_full_reg, aw_full_next;
  logic [7:0] awaddr_q_reg, awaddr_q_next;
  logic w_full_reg, w_full_next;
  logic [31:0] wdata_q_reg, wdata_q_next;
  logic [3:0] wstrb_q_reg, wstrb_q_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic rx_tgl_meta_reg, rx_tgl_sync_reg;

  // link side state read here through the toggle handshake
  logic rx_tgl_reg;
  logic [WORD_BITS-1:0] rx_word_l_reg;
  logic [SW-1:0] rx_slot_l_reg;

  always_comb begin
    rx_en_next = rx_en_reg;
    tx_en_next = tx_en_reg;
    tx_data_next = tx_data_reg;
    mode_next = mode_reg;
    tx_tgl_next = tx_tgl_reg;
    rx_word_q_next = rx_word_q_reg;
    rx_slot_q_next = rx_slot_q_reg;
    rx_fresh_next = rx_fresh_reg;
    rx_seen_next = rx_seen_reg;
    aw_full_next = aw_full_reg;
    awaddr_q_next = awaddr_q_reg;
    w_full_next = w_full_reg;
    wdata_q_next = wdata_q_reg;
    wstrb_q_next = wstrb_q_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_q_next = awaddr;
    end
    if (wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_q_next = wdata;
      wstrb_q_next = wstrb;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = codec_slot_pkg::RESP_OKAY;
      unique case (awaddr_q_reg)
        codec_slot_pkg::RX_EN_ADDR: begin
          rx_en_next = merge16(rx_en_reg, wdata_q_reg, wstrb_q_reg);
        end
        codec_slot_pkg::TX_EN_ADDR: begin
          tx_en_next = merge16(tx_en_reg, wdata_q_reg, wstrb_q_reg);
        end
        codec_slot_pkg::CTRL_ADDR: begin
          if (wstrb_q_reg[0]) mode_next = wdata_q_reg[codec_slot_pkg::CTRL_MODE_BIT];
        end
        codec_slot_pkg::TX_DATA_ADDR: begin
          tx_data_next = merge16(tx_data_reg, wdata_q_reg, wstrb_q_reg);
          tx_tgl_next = ~tx_tgl_reg;
        end
        codec_slot_pkg::RX_DATA_ADDR: begin
        end
        default: begin
          bresp_next = codec_slot_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_full_next;
    wready_next = !w_full_next;
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = codec_slot_pkg::RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (araddr)
        codec_slot_pkg::RX_EN_ADDR: rdata_next[15:0] = rx_en_reg;
        codec_slot_pkg::TX_EN_ADDR: rdata_next[15:0] = tx_en_reg;
        codec_slot_pkg::CTRL_ADDR: rdata_next[codec_slot_pkg::CTRL_MODE_BIT] = mode_reg;
        codec_slot_pkg::TX_DATA_ADDR: rdata_next[15:0] = tx_data_reg;
        codec_slot_pkg::RX_DATA_ADDR: begin
          rdata_next[WORD_BITS-1:0] = rx_word_q_reg;
          rdata_next[codec_slot_pkg::RX_SLOT_LSB +: SW] = rx_slot_q_reg;
          rdata_next[codec_slot_pkg::RX_FRESH_BIT] = rx_fresh_reg;
          rx_fresh_next = 1'b0;
        end
        default: rresp_next = codec_slot_pkg::RESP_SLVERR;
      endcase
    end
    // address is open whenever no read answer is pending, from the first clock after reset
    arready_next = !rvalid_next;
    // a word arriving with the clearing read still marks fresh
    if (rx_tgl_sync_reg != rx_seen_reg) begin
      rx_seen_next = rx_tgl_sync_reg;
      rx_word_q_next = rx_word_l_reg;
      rx_slot_q_next = rx_slot_l_reg;
      rx_fresh_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_en_reg <= codec_slot_pkg::RX_EN_RESET;
      tx_en_reg <= codec_slot_pkg::TX_EN_RESET;
      tx_data_reg <= codec_slot_pkg::TX_DATA_RESET;
      mode_reg <= codec_slot_pkg::CTRL_MODE_RESET;
      tx_tgl_reg <= 1'b0;
      rx_word_q_reg <= '0;
      rx_slot_q_reg <= '0;
      rx_fresh_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      awaddr_q_reg <= 8'h00;
      w_full_reg <= 1'b0;
      wdata_q_reg <= 32'h0000_0000;
      wstrb_q_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      rx_en_reg <= rx_en_next;
      tx_en_reg <= tx_en_next;
      tx_data_reg <= tx_data_next;
      mode_reg <= mode_next;
      tx_tgl_reg <= tx_tgl_next;
      rx_word_q_reg <= rx_word_q_next;
      rx_slot_q_reg <= rx_slot_q_next;
      rx_fresh_reg <= rx_fresh_next;
      rx_seen_reg <= rx_seen_next;
      aw_full_reg <= aw_full_next;
      awaddr_q_reg <= awaddr_q_next;
      w_full_reg <= w_full_next;
      wdata_q_reg <= wdata_q_next;
      wstrb_q_reg <= wstrb_q_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  always_ff @(posedge clk) begin
    rx_tgl_meta_reg <= rx_tgl_reg;
    rx_tgl_sync_reg <= rx_tgl_meta_reg;
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // link side, bit_clk domain
  // config words are level-synchronised: change them between frames
  logic lrst_meta_reg, lrst_reg;
  logic [NS-1:0] rx_en_meta_reg, rx_en_s_reg;
  logic [NS-1:0] tx_en_meta_reg, tx_en_s_reg;
  logic mode_meta_reg, mode_s_reg;
  logic tx_tgl_meta_reg, tx_tgl_s_reg;
  logic tx_seen_reg, tx_seen_next;
  logic [WORD_BITS-1:0] tx_word_l_reg, tx_word_l_next;
  logic [CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
  logic [SW-1:0] slot_reg, slot_next;
  logic [WORD_BITS-1:0] rx_shift_reg, rx_shift_next;
  logic [WORD_BITS-1:0] rx_word_l_next;
  logic [SW-1:0] rx_slot_l_next;
  logic rx_tgl_next;
  logic serial_out_reg, serial_out_next;
  logic serial_oe_n_reg, serial_oe_n_next;
  logic [CNT_W-1:0] bit_idx;
  logic [SW-1:0] slot_idx;
  logic last_bit, rx_take, rx_last, tx_drive, tx_bit;

  always_ff @(posedge bit_clk) begin
    lrst_meta_reg <= rst;
    lrst_reg <= lrst_meta_reg;
    rx_en_meta_reg <= rx_en_reg;
    rx_en_s_reg <= rx_en_meta_reg;
    tx_en_meta_reg <= tx_en_reg;
    tx_en_s_reg <= tx_en_meta_reg;
    mode_meta_reg <= mode_reg;
    mode_s_reg <= mode_meta_reg;
    tx_tgl_meta_reg <= tx_tgl_reg;
    tx_tgl_s_reg <= tx_tgl_meta_reg;
  end

  always_comb begin
    bit_idx = frame_sync ? '0 : bit_cnt_reg;
    slot_idx = frame_sync ? '0 : slot_reg;
    last_bit = (bit_idx == LAST_BIT);
    bit_cnt_next = last_bit ? '0 : bit_idx + 1'b1;
    slot_next = last_bit ? slot_idx + 1'b1 : slot_idx;
    rx_take = rx_en_s_reg[slot_idx];
    rx_last = rx_take && last_bit;
    rx_shift_next = rx_shift_reg;
    rx_word_l_next = rx_word_l_reg;
    rx_slot_l_next = rx_slot_l_reg;
    rx_tgl_next = rx_tgl_reg;
    if (rx_take) begin
      rx_shift_next = {rx_shift_reg[WORD_BITS-2:0], serial_in};
    end
    if (rx_last) begin
      rx_word_l_next = {rx_shift_reg[WORD_BITS-2:0], serial_in};
      rx_slot_l_next = slot_idx;
      rx_tgl_next = ~rx_tgl_reg;
    end
    tx_seen_next = tx_seen_reg;
    tx_word_l_next = tx_word_l_reg;
    // tx_data_reg is stable here: its toggle has already settled
    if (tx_tgl_s_reg != tx_seen_reg) begin
      tx_seen_next = tx_tgl_s_reg;
      tx_word_l_next = tx_data_reg[WORD_BITS-1:0];
    end
    // registered a bit ahead so the codec samples it on the next edge
    tx_drive = tx_en_s_reg[slot_next];
    tx_bit = tx_word_l_reg[LAST_BIT - bit_cnt_next];
    serial_out_next = tx_drive ? tx_bit : 1'b0;
    serial_oe_n_next = tx_drive ? 1'b0 : !mode_s_reg;
  end

  always_ff @(posedge bit_clk) begin
    if (lrst_reg) begin
      tx_seen_reg <= 1'b0;
      tx_word_l_reg <= '0;
      bit_cnt_reg <= '0;
      slot_reg <= '0;
      rx_shift_reg <= '0;
      rx_word_l_reg <= '0;
      rx_slot_l_reg <= '0;
      rx_tgl_reg <= 1'b0;
      serial_out_reg <= 1'b0;
      serial_oe_n_reg <= 1'b1;
    end else begin
      tx_seen_reg <= tx_seen_next;
      tx_word_l_reg <= tx_word_l_next;
      bit_cnt_reg <= bit_cnt_next;
      slot_reg <= slot_next;
      rx_shift_reg <= rx_shift_next;
      rx_word_l_reg <= rx_word_l_next;
      rx_slot_l_reg <= rx_slot_l_next;
      rx_tgl_reg <= rx_tgl_next;
      serial_out_reg <= serial_out_next;
      serial_oe_n_reg <= serial_oe_n_next;
    end
  end

  assign serial_out = serial_out_reg;
  assign serial_out_oe_n = serial_oe_n_reg;

  chk_rx_word_store: assert property (@(posedge bit_clk) disable iff (lrst_reg)
    rx_last |=> (rx_tgl_reg != $past(rx_tgl_reg)) && (rx_word_l_reg[0] == $past(serial_in)))
    else $error("enabled slot end did not store a word");
  chk_rx_skip_slot: assert property (@(posedge bit_clk) disable iff (lrst_reg)
    !rx_take |=> $stable(rx_tgl_reg) && $stable(rx_shift_reg))
    else $error("disabled receive slot changed stored data");
  chk_tx_drive_bit: assert property (@(posedge bit_clk) disable iff (lrst_reg)
    tx_drive |=> !serial_out_oe_n && (serial_out == $past(tx_bit)))
    else $error("enabled transmit slot not driving buffer bit");
  chk_idle_hiz: assert property (@(posedge bit_clk) disable iff (lrst_reg)
    (!tx_drive && !mode_s_reg) |=> serial_out_oe_n)
    else $error("idle slot not released in tri-state mode");
  chk_idle_low: assert property (@(posedge bit_clk) disable iff (lrst_reg)
    (!tx_drive && mode_s_reg) |=> !serial_out_oe_n && !serial_out)
    else $error("idle slot not driven low in low mode");
  chk_frame_restart: assert property (@(posedge bit_clk) disable iff (lrst_reg)
    frame_sync |=> (slot_reg == '0) && (bit_cnt_reg == CNT_W'(1)))
    else $error("slot counter did not restart on frame sync");
  chk_slot_advance: assert property (@(posedge bit_clk) disable iff (lrst_reg)
    (last_bit && !frame_sync) |=> (slot_reg == SW'($past(slot_reg) + 1'b1)))
    else $error("slot counter did not advance at slot end");
endmodule : codec_port_slot_enable
`default_nettype wire

/* File: codec_slot_pkg.sv */
// constants and field layout for the codec port slot gating block
// Function
// - enabled receive slot captures serial input word
// - disabled receive slot ignores input, stores nothing
// - enabled transmit slot shifts out transmit buffer
// - disabled transmit slot: high impedance or low
`default_nettype none
package codec_slot_pkg;
  localparam int unsigned SLOT_COUNT = 16;
  localparam int unsigned SLOT_IDX_BITS = 4;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned ADDR_BITS = 8;
  localparam logic [7:0] RX_EN_ADDR = 8'h00;
  localparam logic [7:0] TX_EN_ADDR = 8'h04;
  localparam logic [7:0] CTRL_ADDR = 8'h08;
  localparam logic [7:0] TX_DATA_ADDR = 8'h0c;
  localparam logic [7:0] RX_DATA_ADDR = 8'h10;
  localparam logic [15:0] RX_EN_RESET = 16'h0000;
  localparam logic [15:0] TX_EN_RESET = 16'h0000;
  localparam logic [15:0] TX_DATA_RESET = 16'h0000;
  localparam logic CTRL_MODE_RESET = 1'b0;
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned RX_SLOT_LSB = 16;
  localparam int unsigned RX_FRESH_BIT = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : codec_slot_pkg
`default_nettype wire

/* File: codec_far_end.sv */
// far-side codec model: bit clock, frame sync, slot words, captured output
`default_nettype none
module codec_far_end (
  output logic bit_clk,
  output logic frame_sync,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  output logic [15:0][15:0] tx_seen,
  output logic [15:0] oe_low,
  output logic [15:0] oe_high,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pos = 8'h00;
  logic [15:0][15:0] sh;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] w;
  function automatic logic [15:0] rx_word(input logic [3:0] s);
    return {4'ha, s, ~s, 4'h5};
  endfunction : rx_word
  initial begin
    bit_clk = 1'b0;
    frames = 0;
    #7;
    forever #15 bit_clk = ~bit_clk;
  end
  // frames stay strictly periodic; the port sends one bit ahead of the sync
  always @(negedge bit_clk) begin
    w = rx_word(pos[7:4]);
    frame_sync <= (pos == 8'h00);
    serial_in <= w[~pos[3:0]];
  end
  always @(posedge bit_clk) begin
    if (pos == 8'h00) begin
      tx_seen <= sh;
      oe_low <= lo;
      oe_high <= hi;
      frames <= frames + 1;
    end
    // a released line has no pull here: show the inverse so a float is caught
    sh[pos[7:4]] <= {sh[pos[7:4]][14:0], serial_out_oe_n ? ~serial_out : serial_out};
    lo[pos[7:4]] <= (lo[pos[7:4]] | (pos[3:0] == 4'h0)) & !serial_out_oe_n;
    hi[pos[7:4]] <= (hi[pos[7:4]] | (pos[3:0] == 4'h0)) & serial_out_oe_n;
    pos <= pos + 8'h01;
  end
endmodule : codec_far_end
`default_nettype wire

/* File: codec_port_slot_enable_tb_top.sv */
// self-checking bench for the codec port slot gating block
`default_nettype none
module codec_port_slot_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic bit_clk, frame_sync, serial_in, serial_out, serial_out_oe_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, r;
  logic [3:0] wstrb, ks;
  logic [1:0] bresp, rresp;
  logic [15:0][15:0] tx_seen;
  logic [15:0] oe_low, oe_high, msk, txd;
  int frames, bad_count, total_checks;
  int mdl [5];
  logic [31:0] seed = 32'h1ec093f2;
  codec_port_slot_enable #(.WORD_BITS(16)) i_dut (.clk(clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bit_clk(bit_clk), .frame_sync(frame_sync),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));
  codec_far_end i_far (.bit_clk(bit_clk), .frame_sync(frame_sync),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .tx_seen(tx_seen), .oe_low(oe_low),
    .oe_high(oe_high), .frames(frames));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand
  // writable bits of each register; zero means nothing is stored
  function automatic logic [31:0] mask(input logic [7:0] a);
    case (a)
      8'h00, 8'h04, 8'h0c: return 32'h0000ffff;
      8'h08: return 32'h00000001;
      default: return 32'h0;
    endcase
  endfunction : mask
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a <= 8'h10 && a[1:0] == 2'b00) ? codec_slot_pkg::RESP_OKAY
                                            : codec_slot_pkg::RESP_SLVERR;
  endfunction : resp_of
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_resp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n == 50)
      bad_count++;
    cmp_resp(bresp, resp_of(a));
    if (mask(a) != 32'h0)
      mdl[a[4:2]] = d & mask(a);
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n == 50)
      bad_count++;
    d = rdata;
    cmp_resp(rresp, resp_of(a));
  endtask : rdr
  // frame count lives in the link domain and is only compared here
  task automatic wait_frames(input int n);
    int f;
    int k;
    f = frames;
    k = 0;
    while (frames < f + n && k < 200 * n) begin
      @(posedge clk);
      k++;
    end
    if (k >= 200 * n)
      bad_count++;
  endtask : wait_frames
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    bad_count = 0;
    total_checks = 0;
    mdl = '{default: 0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      rdr(a[7:0], rd);
      cmp_word(rd, (a < 20) ? mdl[a / 4] : 32'h0);
    end
    wr(8'h14, 32'hffffffff);
    wr(codec_slot_pkg::RX_DATA_ADDR, 32'hffffffff);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      r = next_rand();
      ks = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : r[3:0];
      wr(codec_slot_pkg::RX_EN_ADDR, (32'h1 << ks) | (r & 32'hffff0000));
      rdr(codec_slot_pkg::RX_EN_ADDR, rd);
      cmp_word(rd, mdl[0]);
      wait_frames(2);
      rdr(codec_slot_pkg::RX_DATA_ADDR, rd);
      cmp_word(rd, {1'b1, 11'h0, ks, 4'ha, ks, ~ks, 4'h5});
    end
    wr(codec_slot_pkg::RX_EN_ADDR, 32'h0);
    wait_frames(1);
    rdr(codec_slot_pkg::RX_DATA_ADDR, rd);
    wait_frames(2);
    rdr(codec_slot_pkg::RX_DATA_ADDR, rd);
    cmp_word({31'h0, rd[31]}, 32'h0);
    $display("test receive done");
    for (int m = 0; m < 2; m++) begin
      r = next_rand();
      txd = r[31:16];
      msk = (r[15:0] & 16'h7ffe) | ((m == 0) ? 16'h8001 : 16'h0000);
      wr(codec_slot_pkg::TX_DATA_ADDR, {16'h0, txd});
      wr(codec_slot_pkg::TX_EN_ADDR, {16'h0, msk});
      wr(codec_slot_pkg::CTRL_ADDR, 32'(m));
      rdr(codec_slot_pkg::CTRL_ADDR, rd);
      cmp_word(rd, mdl[2]);
      rdr(codec_slot_pkg::TX_EN_ADDR, rd);
      cmp_word(rd, mdl[1]);
      rdr(codec_slot_pkg::TX_DATA_ADDR, rd);
      cmp_word(rd, mdl[3]);
      wait_frames(2);
      for (int s = 0; s < 16; s++) begin
        if (msk[s]) begin
          cmp_word({16'h0, tx_seen[s]}, {16'h0, txd});
          cmp_word({31'h0, oe_low[s]}, 32'h1);
        end else if (m == 1) begin
          cmp_word({16'h0, tx_seen[s]}, 32'h0);
          cmp_word({31'h0, oe_low[s]}, 32'h1);
        end else begin
          cmp_word({31'h0, oe_high[s]}, 32'h1);
        end
      end
    end
    $display("test transmit done");
    conclude();
  end
  // about 13 frames of traffic are expected; allow ample margin
  initial begin
    #1000000;
    bad_count++;
    conclude();
  end
endmodule : codec_port_slot_enable_tb_top
`default_nettype wire
